// ### pkg/pmps_defs.svh
// Offsets, field positions, reset values and counts for the privileged-mode pipeline sync block
`ifndef PMPS_DEFS_SVH
`define PMPS_DEFS_SVH
`define PMPS_OFF_ICTL 8'h00
`define PMPS_OFF_ACTL 8'h04
`define PMPS_OFF_SHIFT 8'h08
`define PMPS_OFF_DATA 8'h0c
`define PMPS_OFF_ICLR 8'h10
`define PMPS_OFF_PCTR 8'h14
`define PMPS_OFF_PCFG 8'h18
`define PMPS_OFF_ISTAT 8'h1c
`define PMPS_OFF_IMASK 8'h20
`define PMPS_OFF_STATE 8'h24
`define PMPS_ICTL_SBE_LSB 8
`define PMPS_ICTL_SBE_MASK 32'h0000fcff
`define PMPS_ICTL_WVA_BIT 0
`define PMPS_ICTL_SDE_BIT 1
`define PMPS_ACTL_WVA_BIT 0
`define PMPS_ICTL_RST 32'h00000300
`define PMPS_ACTL_RST 32'h00000000
`define PMPS_SHIFT_BITS 6
`define PMPS_SHIFT_REPS 11
`define PMPS_SB_TAG_MASK 8'h51
`define PMPS_SB_TAG_BASE 8'h40
`define PMPS_INT_PCTR 0
`define PMPS_INT_OVF_STUCK 1
`define PMPS_INT_MISPRED 2
`define PMPS_INT_NUM 3
`define PMPS_PCTR_W 20
`define PMPS_RAS_DEPTH 8
`endif

// ### pkg/pmps_pkg.sv
// Types shared by the privileged-mode pipeline sync block
package pmps_pkg;
	typedef enum logic [2:0] {
		PMPS_BR_NONE,
		PMPS_BR_CALL,
		PMPS_BR_JUMP,
		PMPS_BR_RET,
		PMPS_BR_COR
	} pmps_br_kind_t;
	typedef enum {
		PMPS_CH_IDLE,
		PMPS_CH_SHIFT
	} pmps_chain_st_t;
endpackage

// ### rtl/pmps_ras.sv
// Return-address stack with push and pop for the privileged-mode predictor
`timescale 1ns/100ps
module pmps_ras #(
	parameter int DEPTH = 8,
	parameter int AW = 32
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic push_in,
	input wire logic [AW-1:0] push_addr_in,
	input wire logic pop_in,
	output logic [AW-1:0] top_out,
	output logic empty_out
);
	localparam int PW = $clog2(DEPTH);
	logic [AW-1:0] mem [DEPTH];
	logic [PW:0] cnt_q;
	logic [PW-1:0] ptr_q;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("pmps_ras DEPTH must be a power of two >= 2");
		end
	end

	// Circular stack: overflow overwrites the oldest entry rather than stalling
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ptr_q <= '0;
			cnt_q <= '0;
		end else if (push_in) begin
			ptr_q <= ptr_q + 1'b1;
			if (cnt_q != (PW+1)'(DEPTH)) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end else if (pop_in && cnt_q != '0) begin
			ptr_q <= ptr_q - 1'b1;
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Storage has no reset; the count guards stale entries
	always_ff @(posedge clk_in) begin
		if (push_in) begin
			mem[ptr_q] <= push_addr_in;
		end
	end

	assign top_out = mem[ptr_q - 1'b1];
	assign empty_out = (cnt_q == '0);
endmodule

// ### rtl/pmps_top.sv
// Privileged-mode prediction, internal-register write sync and counter overflow logic
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pmps_defs.svh"
module pmps_top #(
	parameter int AW = 32,
	parameter int RAS_DEPTH = `PMPS_RAS_DEPTH,
	parameter int PCTR_W = `PMPS_PCTR_W
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// AXI4-Lite slave
	input wire logic [7:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [7:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	// Pipeline side
	input wire logic PRIV_MODE_IN,
	input wire logic BR_VALID_IN,
	input wire logic BR_PRIV_IN,
	input wire pmps_pkg::pmps_br_kind_t BR_KIND_IN,
	input wire logic [AW-1:0] BR_HINT_IN,
	input wire logic BR_HINT_PRIV_IN,
	input wire logic TRAP_IN,
	input wire logic [AW-1:0] EXC_PC_IN,
	input wire logic FETCH_BLOCK_IN,
	input wire logic RETIRE_IN,
	input wire logic ITLB_TAG_WR_IN,
	input wire logic ITLB_ENTRY_WR_IN,
	input wire logic [AW-1:0] ITLB_WDATA_IN,
	input wire logic CHAIN_BIT_IN,
	input wire logic PCTR_EVENT_IN,
	input wire logic EXT_IRQ_IN,
	output logic PRED_VALID_OUT,
	output logic PRED_MISS_OUT,
	output logic [AW-1:0] PRED_TARGET_OUT,
	output logic PRED_PRIV_OUT,
	output logic PIPE_STALL_OUT,
	output logic [7:0] SCOREBOARD_OUT,
	output logic ITLB_WE_OUT,
	output logic [AW-1:0] ITLB_TAG_OUT,
	output logic [AW-1:0] ITLB_ENTRY_OUT,
	output logic WIDE_VA_OUT,
	output logic CHAIN_SHIFT_OUT,
	output logic PCTR_OVF_OUT,
	output logic EXT_IRQ_GATED_OUT,
	output logic IRQ_OUT
);
	import pmps_pkg::*;

	initial begin
		if (PCTR_W < 8 || PCTR_W > 32 || AW < 8 || AW > 32) begin
			$error("pmps_top width parameters out of range");
		end
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [7:0] aw_addr_q;
	logic aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic w_have_q;
	logic wr_fire;
	logic [31:0] wr_val;
	logic [31:0] ictl_q;
	logic [31:0] actl_q;
	logic [31:0] actl_pend_q;
	logic actl_pend_v_q;
	logic [31:0] iclr_pend_q;
	logic iclr_pend_v_q;
	logic [PCTR_W-1:0] pctr_q;
	logic pctr_en_q;
	logic [`PMPS_INT_NUM-1:0] istat_q;
	logic [`PMPS_INT_NUM-1:0] imask_q;
	logic [`PMPS_INT_NUM-1:0] ev;
	logic [5:0] chain_sh_q;
	logic [5:0] chain_data_q;
	logic [3:0] chain_cnt_q;
	logic [3:0] chain_reps_q;
	pmps_chain_st_t chain_st_q;
	logic stall_q;

	// Merge byte lanes into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	assign wr_fire = aw_have_q && w_have_q && !BVALID_OUT;

	// Address and data are latched independently so either may arrive first
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			AWREADY_OUT <= 1'b0;
			WREADY_OUT <= 1'b0;
			BVALID_OUT <= 1'b0;
			BRESP_OUT <= 2'b00;
		end else begin
			AWREADY_OUT <= !aw_have_q && !AWREADY_OUT && AWVALID_IN;
			WREADY_OUT <= !w_have_q && !WREADY_OUT && WVALID_IN;
			if (AWVALID_IN && AWREADY_OUT) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= AWADDR_IN;
			end
			if (WVALID_IN && WREADY_OUT) begin
				w_have_q <= 1'b1;
				w_data_q <= WDATA_IN;
				w_strb_q <= WSTRB_IN;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				BVALID_OUT <= 1'b1;
				BRESP_OUT <= (aw_addr_q > `PMPS_OFF_STATE || aw_addr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
			end else if (BVALID_OUT && BREADY_IN) begin
				BVALID_OUT <= 1'b0;
			end
		end
	end

	// Read channel; unmapped addresses answer SLVERR with zero data
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ARREADY_OUT <= 1'b0;
			RVALID_OUT <= 1'b0;
			RDATA_OUT <= 32'h00000000;
			RRESP_OUT <= 2'b00;
		end else begin
			ARREADY_OUT <= !RVALID_OUT && !ARREADY_OUT && ARVALID_IN;
			if (ARVALID_IN && ARREADY_OUT) begin
				RVALID_OUT <= 1'b1;
				RRESP_OUT <= 2'b00;
				unique case (ARADDR_IN)
					`PMPS_OFF_ICTL: RDATA_OUT <= ictl_q;
					`PMPS_OFF_ACTL: RDATA_OUT <= actl_q;
					`PMPS_OFF_SHIFT: RDATA_OUT <= {24'h000000, chain_reps_q, chain_cnt_q};
					`PMPS_OFF_DATA: RDATA_OUT <= {26'h0000000, chain_data_q};
					`PMPS_OFF_PCTR: RDATA_OUT <= 32'(pctr_q);
					`PMPS_OFF_PCFG: RDATA_OUT <= {31'h00000000, pctr_en_q};
					`PMPS_OFF_ISTAT: RDATA_OUT <= 32'(istat_q);
					`PMPS_OFF_IMASK: RDATA_OUT <= 32'(imask_q);
					`PMPS_OFF_STATE: RDATA_OUT <= {29'h00000000, iclr_pend_v_q, actl_pend_v_q, stall_q};
					`PMPS_OFF_ICLR: RDATA_OUT <= 32'h00000000;
					default: begin
						RDATA_OUT <= 32'h00000000;
						RRESP_OUT <= 2'b10;
					end
				endcase
			end else if (RVALID_OUT && RREADY_IN) begin
				RVALID_OUT <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Internal register writes and retire-time sync
	// ------------------------------------------------------------
	logic wr_ictl;
	logic wr_actl;
	logic wr_iclr;
	logic blk_since_ictl_q;
	logic blk_since_actl_q;
	assign wr_ictl = wr_fire && aw_addr_q == `PMPS_OFF_ICTL;
	assign wr_actl = wr_fire && aw_addr_q == `PMPS_OFF_ACTL;
	assign wr_iclr = wr_fire && aw_addr_q == `PMPS_OFF_ICLR;

	// Instruction control applies at once; a repeat identical write in a later block stalls
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ictl_q <= `PMPS_ICTL_RST;
			blk_since_ictl_q <= 1'b0;
		end else begin
			if (FETCH_BLOCK_IN) begin
				blk_since_ictl_q <= 1'b1;
			end
			if (wr_ictl) begin
				ictl_q <= merge(ictl_q, w_data_q, w_strb_q);
				blk_since_ictl_q <= 1'b0;
			end
		end
	end

	// Address control is held pending until the write retires
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			actl_q <= `PMPS_ACTL_RST;
			actl_pend_q <= `PMPS_ACTL_RST;
			actl_pend_v_q <= 1'b0;
			blk_since_actl_q <= 1'b0;
		end else begin
			if (FETCH_BLOCK_IN) begin
				blk_since_actl_q <= 1'b1;
			end
			if (actl_pend_v_q && RETIRE_IN) begin
				actl_q <= actl_pend_q;
				actl_pend_v_q <= 1'b0;
			end
			if (wr_actl) begin
				actl_pend_q <= merge(actl_pend_v_q ? actl_pend_q : actl_q, w_data_q, w_strb_q);
				actl_pend_v_q <= 1'b1;
				blk_since_actl_q <= 1'b0;
			end
		end
	end

	// Interrupt-clear write waits for retire; clears matching status bits
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			iclr_pend_q <= 32'h00000000;
			iclr_pend_v_q <= 1'b0;
		end else begin
			if (iclr_pend_v_q && RETIRE_IN) begin
				iclr_pend_v_q <= 1'b0;
			end
			if (wr_iclr) begin
				iclr_pend_q <= w_data_q;
				iclr_pend_v_q <= 1'b1;
			end
		end
	end

	// Stall sources; a repeated write holds the pipe until the first retires
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			stall_q <= 1'b0;
		end else if (wr_ictl && blk_since_ictl_q && merge(ictl_q, w_data_q, w_strb_q) == ictl_q) begin
			stall_q <= 1'b1;
		end else if (wr_actl && blk_since_actl_q && actl_pend_v_q) begin
			stall_q <= 1'b1;
		end else if (wr_iclr && iclr_pend_v_q) begin
			stall_q <= 1'b1;
		end else if (RETIRE_IN) begin
			stall_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Translation buffer staging
	// ------------------------------------------------------------
	logic tag_stage_v_q;
	logic entry_pend_q;
	logic [AW-1:0] entry_data_q;
	// Tag goes to staging; scoreboard bits 0,4,6 block a second tag until entry write retires
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ITLB_TAG_OUT <= '0;
			ITLB_ENTRY_OUT <= '0;
			ITLB_WE_OUT <= 1'b0;
			SCOREBOARD_OUT <= 8'h00;
			tag_stage_v_q <= 1'b0;
			entry_pend_q <= 1'b0;
			entry_data_q <= '0;
		end else begin
			ITLB_WE_OUT <= 1'b0;
			if (ITLB_TAG_WR_IN && !tag_stage_v_q) begin
				ITLB_TAG_OUT <= ITLB_WDATA_IN;
				tag_stage_v_q <= 1'b1;
				SCOREBOARD_OUT <= `PMPS_SB_TAG_MASK;
			end
			// Entry write is held until it retires, so a flushed write never reaches the buffer
			if (ITLB_ENTRY_WR_IN && tag_stage_v_q) begin
				entry_data_q <= ITLB_WDATA_IN;
				entry_pend_q <= 1'b1;
			end
			if (entry_pend_q && RETIRE_IN) begin
				ITLB_ENTRY_OUT <= entry_data_q;
				ITLB_WE_OUT <= 1'b1;
				tag_stage_v_q <= 1'b0;
				entry_pend_q <= 1'b0;
				SCOREBOARD_OUT <= 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Cache-box chain shifter
	// ------------------------------------------------------------
	logic wr_shift;
	assign wr_shift = wr_fire && aw_addr_q == `PMPS_OFF_SHIFT;
	// Each command shifts 6 bits in serially; the reps counter tracks the eleven passes
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			chain_st_q <= PMPS_CH_IDLE;
			chain_sh_q <= 6'h00;
			chain_data_q <= 6'h00;
			chain_cnt_q <= 4'h0;
			chain_reps_q <= 4'h0;
			CHAIN_SHIFT_OUT <= 1'b0;
		end else begin
			unique case (chain_st_q)
				PMPS_CH_IDLE: begin
					CHAIN_SHIFT_OUT <= 1'b0;
					if (wr_shift) begin
						chain_st_q <= PMPS_CH_SHIFT;
						chain_cnt_q <= 4'(`PMPS_SHIFT_BITS);
						CHAIN_SHIFT_OUT <= 1'b1;
					end
				end
				PMPS_CH_SHIFT: begin
					chain_sh_q <= {chain_sh_q[4:0], CHAIN_BIT_IN};
					chain_cnt_q <= chain_cnt_q - 4'h1;
					if (chain_cnt_q == 4'h1) begin
						chain_st_q <= PMPS_CH_IDLE;
						CHAIN_SHIFT_OUT <= 1'b0;
						chain_data_q <= {chain_sh_q[4:0], CHAIN_BIT_IN};
						chain_reps_q <= (chain_reps_q == 4'(`PMPS_SHIFT_REPS - 1)) ? 4'h0 : chain_reps_q + 4'h1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Prediction
	// ------------------------------------------------------------
	logic [AW-1:0] ras_top;
	logic ras_empty;
	logic ras_pop;
	logic nat_ret;
	assign nat_ret = BR_VALID_IN && BR_PRIV_IN && BR_KIND_IN == PMPS_BR_RET && !BR_HINT_PRIV_IN;
	assign ras_pop = nat_ret && !ras_empty;

	pmps_ras #(
		.DEPTH(RAS_DEPTH),
		.AW(AW)
	) u_ras (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.push_in(TRAP_IN),
		.push_addr_in(EXC_PC_IN),
		.pop_in(ras_pop),
		.top_out(ras_top),
		.empty_out(ras_empty)
	);

	// Predicted target per branch kind and mode
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PRED_VALID_OUT <= 1'b0;
			PRED_MISS_OUT <= 1'b0;
			PRED_TARGET_OUT <= '0;
			PRED_PRIV_OUT <= 1'b0;
		end else begin
			PRED_VALID_OUT <= BR_VALID_IN && BR_KIND_IN != PMPS_BR_NONE;
			PRED_MISS_OUT <= 1'b0;
			PRED_TARGET_OUT <= BR_HINT_IN;
			PRED_PRIV_OUT <= PRIV_MODE_IN;
			if (BR_VALID_IN && !BR_PRIV_IN && PRIV_MODE_IN) begin
				PRED_MISS_OUT <= 1'b1;
			end else if (BR_VALID_IN && BR_PRIV_IN && BR_KIND_IN == PMPS_BR_RET) begin
				PRED_PRIV_OUT <= 1'b0;
				if (BR_HINT_PRIV_IN || ras_empty) begin
					PRED_MISS_OUT <= 1'b1;
				end else begin
					PRED_TARGET_OUT <= ras_top;
				end
			end else if (BR_VALID_IN && BR_PRIV_IN) begin
				PRED_TARGET_OUT <= BR_HINT_IN;
				PRED_PRIV_OUT <= BR_HINT_PRIV_IN && PRIV_MODE_IN;
			end
		end
	end

	// ------------------------------------------------------------
	// Performance counter and interrupts
	// ------------------------------------------------------------
	logic at_ovf;
	logic wr_pctr;
	assign at_ovf = &pctr_q;
	assign wr_pctr = wr_fire && aw_addr_q == `PMPS_OFF_PCTR;

	// Enabled: wrap clears; disabled at top: count not updated, overflow repeats
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pctr_q <= '0;
			pctr_en_q <= 1'b0;
			PCTR_OVF_OUT <= 1'b0;
		end else begin
			PCTR_OVF_OUT <= 1'b0;
			if (wr_fire && aw_addr_q == `PMPS_OFF_PCFG && w_strb_q[0]) begin
				pctr_en_q <= w_data_q[0];
			end
			if (wr_pctr) begin
				pctr_q <= PCTR_W'(w_data_q);
			end else if (pctr_en_q && PCTR_EVENT_IN) begin
				pctr_q <= pctr_q + 1'b1;
				if (at_ovf) begin
					pctr_q <= '0;
					PCTR_OVF_OUT <= 1'b1;
				end
			end else if (!pctr_en_q && at_ovf) begin
				PCTR_OVF_OUT <= 1'b1;
			end
		end
	end

	assign ev[`PMPS_INT_PCTR] = pctr_en_q && PCTR_EVENT_IN && at_ovf && !wr_pctr;
	assign ev[`PMPS_INT_OVF_STUCK] = !pctr_en_q && at_ovf;
	assign ev[`PMPS_INT_MISPRED] = BR_VALID_IN && !BR_PRIV_IN && PRIV_MODE_IN;

	// Status is sticky, cleared by writing one or by a retired clear; set wins
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			istat_q <= '0;
			imask_q <= '0;
		end else begin
			if (wr_fire && aw_addr_q == `PMPS_OFF_IMASK) begin
				imask_q <= w_data_q[`PMPS_INT_NUM-1:0];
			end
			istat_q <= (istat_q
				& ~((wr_fire && aw_addr_q == `PMPS_OFF_ISTAT) ? w_data_q[`PMPS_INT_NUM-1:0] : '0)
				& ~((iclr_pend_v_q && RETIRE_IN) ? iclr_pend_q[`PMPS_INT_NUM-1:0] : '0))
				| ev;
		end
	end

	// Outgoing pipeline flags; overflow blocks the external interrupt request while it lasts
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			IRQ_OUT <= 1'b0;
			EXT_IRQ_GATED_OUT <= 1'b0;
			PIPE_STALL_OUT <= 1'b0;
			WIDE_VA_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(istat_q & imask_q);
			EXT_IRQ_GATED_OUT <= EXT_IRQ_IN && !ev[`PMPS_INT_PCTR] && !ev[`PMPS_INT_OVF_STUCK];
			PIPE_STALL_OUT <= stall_q;
			WIDE_VA_OUT <= actl_q[`PMPS_ACTL_WVA_BIT] | ictl_q[`PMPS_ICTL_WVA_BIT];
		end
	end
endmodule

// ### sim/pmps_top_sva.sv
// Port timing checker for the privileged-mode pipeline sync block
`timescale 1ns/100ps
module pmps_top_sva #(
	parameter int AW = 32
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic AWREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic PRIV_MODE_IN,
	input wire logic BR_VALID_IN,
	input wire logic BR_PRIV_IN,
	input wire pmps_pkg::pmps_br_kind_t BR_KIND_IN,
	input wire logic [AW-1:0] BR_HINT_IN,
	input wire logic BR_HINT_PRIV_IN,
	input wire logic RETIRE_IN,
	input wire logic ITLB_TAG_WR_IN,
	input wire logic PRED_VALID_OUT,
	input wire logic PRED_MISS_OUT,
	input wire logic [AW-1:0] PRED_TARGET_OUT,
	input wire logic PRED_PRIV_OUT,
	input wire logic PIPE_STALL_OUT,
	input wire logic [7:0] SCOREBOARD_OUT,
	input wire logic CHAIN_SHIFT_OUT,
	input wire logic PCTR_OVF_OUT
);
	import pmps_pkg::*;
	// ----------------------------------------
	// One clock domain, so clock and reset are given once
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// Bus handshake: address ready pulses, read data follows the next cycle, answers stand until taken
	a_ready_pulse: assert property (AWREADY_OUT |=> !AWREADY_OUT)
		else $error("write address ready held");
	a_bresp_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
		else $error("write response dropped");
	a_rdata_hold: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
		else $error("read data dropped");
	a_read_late: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("read data late");
	// Prediction one cycle after the branch
	a_pred_valid: assert property (BR_VALID_IN |=> PRED_VALID_OUT)
		else $error("prediction missing");
	a_unpriv_miss: assert property (BR_VALID_IN && PRIV_MODE_IN && !BR_PRIV_IN && BR_KIND_IN != PMPS_BR_NONE
		|=> PRED_MISS_OUT)
		else $error("unprivileged branch predicted");
	a_ret_priv: assert property (BR_VALID_IN && BR_PRIV_IN && BR_KIND_IN == PMPS_BR_RET && BR_HINT_PRIV_IN
		|=> PRED_MISS_OUT)
		else $error("privileged target return predicted");
	a_hint_target: assert property (BR_VALID_IN && BR_PRIV_IN && BR_KIND_IN != PMPS_BR_RET
		&& BR_KIND_IN != PMPS_BR_NONE
		|=> PRED_TARGET_OUT == $past(BR_HINT_IN)
		&& PRED_PRIV_OUT == ($past(BR_HINT_PRIV_IN) && $past(PRIV_MODE_IN)))
		else $error("hint target not used");
	a_chain_six: assert property ($rose(CHAIN_SHIFT_OUT) |-> CHAIN_SHIFT_OUT [*6] ##1 !CHAIN_SHIFT_OUT)
		else $error("chain shift length wrong");
	a_tag_guard: assert property (ITLB_TAG_WR_IN |-> ##[1:2] SCOREBOARD_OUT == 8'h51)
		else $error("staged tag unguarded");
	a_stall_clear: assert property (RETIRE_IN |-> ##2 !PIPE_STALL_OUT)
		else $error("stall outlives retire");
	// Main scenarios reached
	c_stall: cover property (PIPE_STALL_OUT);
	c_ovf: cover property (PCTR_OVF_OUT);
	c_chain: cover property ($fell(CHAIN_SHIFT_OUT));
endmodule

bind pmps_top pmps_top_sva #(.AW(AW)) u_sva (.*);

// ### sim/testbench.sv
// Self-checking bench for the privileged-mode pipeline sync block
`timescale 1ns/100ps
`include "pmps_defs.svh"
module testbench;
	import pmps_pkg::*;
	// ----------------------------------------
	// Signals, named as the ports so the instance connects by name
	// ----------------------------------------
	logic CLK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic [7:0] AWADDR_IN = 8'h00, ARADDR_IN = 8'h00;
	logic AWVALID_IN = 1'b0, WVALID_IN = 1'b0, BREADY_IN = 1'b0, ARVALID_IN = 1'b0, RREADY_IN = 1'b0;
	logic [31:0] WDATA_IN = 32'h0, BR_HINT_IN = 32'h0, EXC_PC_IN = 32'h0, ITLB_WDATA_IN = 32'h0;
	logic [3:0] WSTRB_IN = 4'hf;
	logic PRIV_MODE_IN = 1'b0, BR_VALID_IN = 1'b0, BR_PRIV_IN = 1'b0, BR_HINT_PRIV_IN = 1'b0, EXT_IRQ_IN = 1'b0;
	pmps_br_kind_t BR_KIND_IN = PMPS_BR_NONE;
	logic [5:0] pls = 6'h00, pat = 6'h00;
	logic [5:0] cp [2] = '{6'h2d, 6'h13};
	logic [2:0] ccnt = 3'd0;
	logic TRAP_IN, FETCH_BLOCK_IN, RETIRE_IN, ITLB_TAG_WR_IN, ITLB_ENTRY_WR_IN, PCTR_EVENT_IN, CHAIN_BIT_IN;
	logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT, PRED_VALID_OUT, PRED_MISS_OUT;
	logic PRED_PRIV_OUT, PIPE_STALL_OUT, ITLB_WE_OUT, WIDE_VA_OUT, CHAIN_SHIFT_OUT, PCTR_OVF_OUT;
	logic EXT_IRQ_GATED_OUT, IRQ_OUT;
	logic [1:0] BRESP_OUT, RRESP_OUT, bresp, rresp;
	logic [7:0] SCOREBOARD_OUT;
	logic [31:0] RDATA_OUT, PRED_TARGET_OUT, ITLB_TAG_OUT, ITLB_ENTRY_OUT, rv;
	int error_cnt = 0, num_checks = 0, ovf_n = 0, gap_n = 0, we_n = 0, o0, g0;

	pmps_top dut (.*);

	always #12.5 CLK_IN = ~CLK_IN;
	// One-cycle strobes share a vector so a task can raise any of them
	assign {PCTR_EVENT_IN, ITLB_ENTRY_WR_IN, ITLB_TAG_WR_IN, RETIRE_IN, FETCH_BLOCK_IN, TRAP_IN} = pls;
	// Chain source, MSB first; idle bit differs so stale sampling shows
	always @(posedge CLK_IN) ccnt <= (CHAIN_SHIFT_OUT === 1'b1) ? ccnt + 3'd1 : 3'd0;
	assign CHAIN_BIT_IN = (ccnt < 3'd6) ? pat[3'd5 - ccnt] : ~pat[0];
	// Event counters sample mid-cycle, away from the launching edge
	always @(negedge CLK_IN) begin
		if (PCTR_OVF_OUT === 1'b1) ovf_n++;
		if (ITLB_WE_OUT === 1'b1) we_n++;
		if (EXT_IRQ_IN && EXT_IRQ_GATED_OUT !== 1'b1) gap_n++;
	end

	// ----------------------------------------
	// Tasks; each driving task starts on a fresh edge so no signal is set twice
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_IN);
		AWADDR_IN <= a;
		WDATA_IN <= d;
		AWVALID_IN <= 1'b1;
		WVALID_IN <= 1'b1;
		BREADY_IN <= 1'b1;
		do begin
			@(posedge CLK_IN);
			if (AWREADY_OUT === 1'b1) AWVALID_IN <= 1'b0;
			if (WREADY_OUT === 1'b1) WVALID_IN <= 1'b0;
		end while (BVALID_OUT !== 1'b1);
		BREADY_IN <= 1'b0;
		bresp = BRESP_OUT;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge CLK_IN);
		ARADDR_IN <= a;
		ARVALID_IN <= 1'b1;
		RREADY_IN <= 1'b1;
		do begin
			@(posedge CLK_IN);
			if (ARREADY_OUT === 1'b1) ARVALID_IN <= 1'b0;
		end while (RVALID_OUT !== 1'b1);
		RREADY_IN <= 1'b0;
		rv = RDATA_OUT;
		rresp = RRESP_OUT;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, rv, e);
	endtask
	task automatic pulse(input int k);
		@(posedge CLK_IN);
		pls <= 6'h01 << k;
		@(posedge CLK_IN);
		pls <= 6'h00;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge CLK_IN);
	endtask
	// Returns on the edge after the prediction register loaded
	task automatic br(input logic p, input pmps_br_kind_t k, input logic [31:0] h, input logic hp);
		@(posedge CLK_IN);
		BR_VALID_IN <= 1'b1;
		BR_PRIV_IN <= p;
		BR_KIND_IN <= k;
		BR_HINT_IN <= h;
		BR_HINT_PRIV_IN <= hp;
		@(posedge CLK_IN);
		BR_VALID_IN <= 1'b0;
		@(posedge CLK_IN);
	endtask
	// Same write in two fetch blocks: stall until retire, then drain
	task automatic dup(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		pulse(1);
		wr(a, d);
		wt(2);
		chk("dup stall", PIPE_STALL_OUT, 32'h1);
		pulse(2);
		wt(2);
		chk("dup unstall", PIPE_STALL_OUT, 32'h0);
		pulse(2);
		wt(2);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		#500000;
		error_cnt++;
		stop_test();
	end
	// No privileged load is ever issued here, so the fetch-slot limit is kept
	initial begin
		wt(10);
		RST_N_IN <= 1'b1;
		rchk("ictl reset", `PMPS_OFF_ICTL, `PMPS_ICTL_RST);
		rchk("actl reset", `PMPS_OFF_ACTL, `PMPS_ACTL_RST);
		rchk("unmapped read", 8'h40, 32'h0);
		chk("unmapped rresp", rresp, 32'h2);
		wr(8'h44, 32'h1);
		chk("unmapped bresp", bresp, 32'h2);
		PRIV_MODE_IN <= 1'b1;
		for (int k = 1; k < 5; k++) begin
			br(1'b0, pmps_br_kind_t'(k), 32'h0, 1'b0);
			chk("unpriv miss", PRED_MISS_OUT, 32'h1);
			chk("pred valid", PRED_VALID_OUT, 32'h1);
		end
		EXC_PC_IN <= 32'h0000_1230;
		pulse(0);
		br(1'b1, PMPS_BR_RET, 32'h0, 1'b0);
		chk("ret target", PRED_TARGET_OUT, 32'h1230);
		chk("ret hit", PRED_MISS_OUT, 32'h0);
		pulse(0);
		br(1'b1, PMPS_BR_RET, 32'h1230, 1'b1);
		chk("priv ret miss", PRED_MISS_OUT, 32'h1);
		for (int k = 1; k < 5; k++) if (k != 3) begin
			br(1'b1, pmps_br_kind_t'(k), 32'h2000 + k, k[0]);
			chk("hint target", PRED_TARGET_OUT, 32'h2000 + k);
			chk("hint mode", PRED_PRIV_OUT, k[0]);
		end
		PRIV_MODE_IN <= 1'b0;
		wr(`PMPS_OFF_ISTAT, 32'h7);
		rchk("status cleared", `PMPS_OFF_ISTAT, 32'h0);
		wr(`PMPS_OFF_ICTL, `PMPS_ICTL_RST & `PMPS_ICTL_SBE_MASK);
		foreach (cp[i]) begin
			pat <= cp[i];
			wr(`PMPS_OFF_SHIFT, 32'h0);
			wt(9);
			rchk("chain bits", `PMPS_OFF_DATA, {26'h0, cp[i]});
			rchk("chain left", `PMPS_OFF_SHIFT, 32'(i + 1) << 4);
		end
		wr(`PMPS_OFF_ICTL, `PMPS_ICTL_RST);
		wr(`PMPS_OFF_ACTL, 32'h1);
		wt(2);
		chk("actl pending", WIDE_VA_OUT, 32'h0);
		pulse(2);
		wt(2);
		chk("actl retired", WIDE_VA_OUT, 32'h1);
		dup(`PMPS_OFF_ACTL, 32'h0);
		chk("actl cleared", WIDE_VA_OUT, 32'h0);
		wr(`PMPS_OFF_ICTL, 32'h301);
		wr(`PMPS_OFF_ICTL, 32'h301);
		wt(2);
		chk("same block", PIPE_STALL_OUT, 32'h0);
		dup(`PMPS_OFF_ICTL, 32'h301);
		repeat (3) pulse(1);
		chk("ictl wide", WIDE_VA_OUT, 32'h1);
		dup(`PMPS_OFF_ICLR, 32'h1);
		ITLB_WDATA_IN <= 32'h0000_a000;
		pulse(3);
		wt(2);
		chk("tag guard", SCOREBOARD_OUT, 32'h51);
		ITLB_WDATA_IN <= 32'h0000_0b07;
		pulse(4);
		wt(3);
		chk("no early write", we_n, 32'h0);
		pulse(2);
		wt(3);
		chk("one write", we_n, 32'h1);
		chk("tag out", ITLB_TAG_OUT, 32'ha000);
		chk("entry out", ITLB_ENTRY_OUT, 32'h0b07);
		chk("tag unguard", SCOREBOARD_OUT, 32'h0);
		EXT_IRQ_IN <= 1'b1;
		wr(`PMPS_OFF_PCFG, 32'h1);
		wr(`PMPS_OFF_IMASK, 32'h7);
		wr(`PMPS_OFF_PCTR, 32'h000ffffe);
		o0 = ovf_n;
		g0 = gap_n;
		pulse(5);
		pulse(5);
		wt(3);
		chk("one ovf", ovf_n - o0, 32'h1);
		chk("short block", gap_n - g0 <= 1, 32'h1);
		chk("irq raised", IRQ_OUT, 32'h1);
		rchk("ctr cleared", `PMPS_OFF_PCTR, 32'h0);
		rchk("ovf status", `PMPS_OFF_ISTAT, 32'h1);
		wr(`PMPS_OFF_IMASK, 32'h0);
		wt(2);
		chk("irq masked", IRQ_OUT, 32'h0);
		wr(`PMPS_OFF_IMASK, 32'h7);
		wr(`PMPS_OFF_ISTAT, 32'h1);
		wt(2);
		chk("irq cleared", IRQ_OUT, 32'h0);
		wr(`PMPS_OFF_PCFG, 32'h0);
		wr(`PMPS_OFF_PCTR, 32'h000fffff);
		o0 = ovf_n;
		g0 = gap_n;
		wt(6);
		chk("stuck ovf", ovf_n - o0 > 2, 32'h1);
		chk("stuck block", gap_n - g0 > 2, 32'h1);
		rd(`PMPS_OFF_ISTAT);
		chk("stuck status", rv[1], 32'h1);
		wr(`PMPS_OFF_PCTR, 32'h0);
		stop_test();
	end
endmodule
